//--- core/gpl_port.sv
`timescale 1ns/100ps
module gpl_port
  import gpl_pkg::*;
#(
  parameter logic [4:0] BUS_ADDR = 5'h0A
)
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       atn_b_i,
  input  wire logic       ifc_b_i,
  input  wire logic       ren_b_i,
  input  wire logic       dav_b_i,
  input  wire logic       nrfd_b_i,
  input  wire logic       ndac_b_i,
  input  wire logic       eoi_b_i,
  input  wire logic [7:0] dio_b_i,
  output logic      [7:0] dio_b_o,
  output logic      [7:0] dio_oe_o,
  output logic            dav_b_o,
  output logic            dav_oe_o,
  output logic            nrfd_b_o,
  output logic            nrfd_oe_o,
  output logic            ndac_b_o,
  output logic            ndac_oe_o,
  output logic            srq_b_o,
  output logic            srq_oe_o,
  input  wire logic       cmd_set_i,
  input  wire logic       remote_req_i,
  input  wire logic       remote_val_i,
  input  wire logic       lockout_val_i,
  output logic            remote_o,
  output logic            lockout_o,
  output logic            ctrl_present_o,
  output logic            legacy_sel_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  input  wire logic       rx_ready_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  input  wire logic       tx_last_i,
  output logic            tx_ready_o,
  output logic            dev_clear_o
);
  // ==========================================================
  // Synchronised bus
  gpl_sync_if bus ();

  gpl_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .atn_b_i   (atn_b_i),
    .ifc_b_i   (ifc_b_i),
    .ren_b_i   (ren_b_i),
    .dav_b_i   (dav_b_i),
    .nrfd_b_i  (nrfd_b_i),
    .ndac_b_i  (ndac_b_i),
    .eoi_b_i   (eoi_b_i),
    .dio_b_i   (dio_b_i),
    .bus       (bus)
  );

  // ==========================================================
  // Acceptor handshake
  logic       dav_q;
  logic       rx_hold;
  logic       dav_rise;
  logic       listen;
  logic       talk;
  logic       spoll;
  logic [7:0] cmd;

  assign dav_rise = bus.dav & ~dav_q;
  assign cmd      = {1'b0, bus.dio[6:0]};

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dav_q <= 1'b0;
    end else begin
      dav_q <= bus.dav;
    end
  end

  // Addressing and serial poll mode, cleared by IFC
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      listen <= 1'b0;
      talk   <= 1'b0;
      spoll  <= 1'b0;
    end else if (bus.ifc) begin
      listen <= 1'b0;
      talk   <= 1'b0;
      spoll  <= 1'b0;
    end else if (dav_rise && bus.atn) begin
      if (cmd == GPL_MSG_UNL) begin
        listen <= 1'b0;
      end else if (cmd == GPL_MSG_UNT) begin
        talk <= 1'b0;
      end else if (cmd[6:5] == GPL_GRP_LAG[1:0]) begin
        if (cmd[4:0] == BUS_ADDR) begin
          listen <= 1'b1;
        end
      end else if (cmd[6:5] == GPL_GRP_TAG[1:0]) begin
        talk <= (cmd[4:0] == BUS_ADDR);
      end else if (cmd == GPL_MSG_SPE) begin
        spoll <= 1'b1;
      end else if (cmd == GPL_MSG_SPD) begin
        spoll <= 1'b0;
      end
      // Lockout, go-to-local and parallel poll messages fall through
    end
  end

  // Device clear: DCL always, SDC when listening
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dev_clear_o <= 1'b0;
    end else begin
      dev_clear_o <= dav_rise & bus.atn & ~bus.ifc &
                     ((cmd == GPL_MSG_DCL) | (cmd == GPL_MSG_SDC & listen));
    end
  end

  // Data byte reception
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_hold   <= 1'b0;
      rx_data_o <= 8'h00;
    end else if (!rx_hold) begin
      if (dav_rise && !bus.atn && listen && !bus.ifc) begin
        rx_hold   <= 1'b1;
        rx_data_o <= bus.dio;
      end
    end else if (rx_ready_i) begin
      rx_hold <= 1'b0;
    end
  end

  assign rx_valid_o = rx_hold;

  // ==========================================================
  // Source handshake
  gpl_sh_t    sh;
  logic [7:0] stb;
  logic [7:0] tx_byte;
  logic       tx_take;
  logic       sh_drive;

  assign tx_take    = (sh == GPL_SH_IDLE) & talk & ~spoll & ~bus.atn &
                      ~bus.ifc;
  assign tx_ready_o = tx_take;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sh      <= GPL_SH_IDLE;
      tx_byte <= 8'h00;
    end else if (bus.ifc || bus.atn || !talk) begin
      sh <= GPL_SH_IDLE;
    end else begin
      case (sh)
        GPL_SH_IDLE: begin
          if (spoll) begin
            tx_byte <= stb;
            sh      <= GPL_SH_WAIT;
          end else if (tx_valid_i) begin
            tx_byte <= tx_data_i;
            sh      <= GPL_SH_WAIT;
          end
        end
        GPL_SH_WAIT: begin
          if (!bus.nrfd) begin
            sh <= GPL_SH_DRIV;
          end
        end
        GPL_SH_DRIV: begin
          if (!bus.ndac) begin
            sh <= GPL_SH_DONE;
          end
        end
        GPL_SH_DONE: begin
          if (!spoll) begin
            sh <= GPL_SH_IDLE;
          end
        end
        default: sh <= GPL_SH_IDLE;
      endcase
    end
  end

  assign sh_drive = (sh == GPL_SH_WAIT) | (sh == GPL_SH_DRIV);

  // ==========================================================
  // Status byte and service request
  logic       bav;
  logic       mav;
  logic       rqs;
  logic       stb_read;

  assign stb_read = (sh == GPL_SH_DRIV) & ~bus.ndac & spoll;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bav <= 1'b0;
      mav <= 1'b0;
    end else begin
      bav <= tx_valid_i;
      mav <= tx_valid_i & tx_last_i;
    end
  end

  // New message sets RQS only while not talk-addressed, so the clear by the poll always wins
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rqs <= 1'b0;
    end else if (tx_valid_i && tx_last_i && !mav && !talk) begin
      rqs <= 1'b1;
    end else if (stb_read) begin
      rqs <= 1'b0;
    end
  end

  always_comb begin
    stb                  = GPL_STB_RESET;
    stb[GPL_STB_RQS_BIT] = rqs;
    stb[GPL_STB_MAV_BIT] = mav;
    stb[GPL_STB_BAV_BIT] = bav;
  end

  // ==========================================================
  // Pin drivers; data lines released outside own transfers
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dio_oe_o  <= 8'h00;
      dav_oe_o  <= 1'b0;
      nrfd_oe_o <= 1'b0;
      ndac_oe_o <= 1'b0;
      srq_oe_o  <= 1'b0;
    end else begin
      dio_oe_o  <= (sh_drive & ~bus.atn) ? tx_byte : 8'h00;
      dav_oe_o  <= (sh == GPL_SH_DRIV) & ~bus.atn;
      nrfd_oe_o <= listen & ~bus.atn & (rx_hold | dav_q);
      ndac_oe_o <= (listen | bus.atn) & ~(dav_q & ~bus.ifc);
      srq_oe_o  <= rqs;
    end
  end

  assign dio_b_o  = 8'h00;
  assign dav_b_o  = 1'b0;
  assign nrfd_b_o = 1'b0;
  assign ndac_b_o = 1'b0;
  assign srq_b_o  = 1'b0;

  // ==========================================================
  // Control functions; remote and lockout untouched by REN and IFC, controller-present flag follows REN
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      remote_o  <= 1'b0;
      lockout_o <= 1'b0;
    end else if (remote_req_i) begin
      remote_o  <= remote_val_i;
      lockout_o <= lockout_val_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_present_o <= 1'b0;
      legacy_sel_o   <= 1'b0;
    end else begin
      ctrl_present_o <= bus.ren;
      legacy_sel_o   <= (cmd_set_i == GPL_SET_LEGACY);
    end
  end
endmodule : gpl_port

//--- core/gpl_pkg.sv
package gpl_pkg;
  // ==========================================================
  // Status byte layout
  localparam int unsigned GPL_STB_RQS_BIT = 6;
  localparam int unsigned GPL_STB_MAV_BIT = 4;
  localparam int unsigned GPL_STB_BAV_BIT = 1;
  localparam logic [7:0]  GPL_STB_RESET   = 8'h00;

  // ==========================================================
  // Bus messages (low seven bits of a command byte, ATN true)
  localparam logic [7:0] GPL_MSG_GTL = 8'h01;
  localparam logic [7:0] GPL_MSG_SDC = 8'h04;
  localparam logic [7:0] GPL_MSG_PPC = 8'h05;
  localparam logic [7:0] GPL_MSG_LLO = 8'h11;
  localparam logic [7:0] GPL_MSG_DCL = 8'h14;
  localparam logic [7:0] GPL_MSG_PPU = 8'h15;
  localparam logic [7:0] GPL_MSG_SPE = 8'h18;
  localparam logic [7:0] GPL_MSG_SPD = 8'h19;
  localparam logic [7:0] GPL_MSG_UNL = 8'h3F;
  localparam logic [7:0] GPL_MSG_UNT = 8'h5F;
  localparam logic [2:0] GPL_GRP_LAG = 3'h1;
  localparam logic [2:0] GPL_GRP_TAG = 3'h2;

  // ==========================================================
  // Command set selection
  typedef enum logic [0:0] {
    GPL_SET_SCPI   = 1'b0,
    GPL_SET_LEGACY = 1'b1
  } gpl_cmdset_t;

  // ==========================================================
  // Source handshake states
  typedef enum logic [3:0] {
    GPL_SH_IDLE = 4'b0001,
    GPL_SH_WAIT = 4'b0010,
    GPL_SH_DRIV = 4'b0100,
    GPL_SH_DONE = 4'b1000
  } gpl_sh_t;
endpackage : gpl_pkg

//--- core/gpl_sync_if.sv
`timescale 1ns/100ps
interface gpl_sync_if;
  logic       atn;
  logic       ifc;
  logic       ren;
  logic       dav;
  logic       nrfd;
  logic       ndac;
  logic       eoi;
  logic [7:0] dio;

  modport src (output atn, ifc, ren, dav, nrfd, ndac, eoi, dio);
  modport dst (input  atn, ifc, ren, dav, nrfd, ndac, eoi, dio);
endinterface : gpl_sync_if

//--- core/gpl_sync.sv
`timescale 1ns/100ps
module gpl_sync
  import gpl_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       atn_b_i,
  input  wire logic       ifc_b_i,
  input  wire logic       ren_b_i,
  input  wire logic       dav_b_i,
  input  wire logic       nrfd_b_i,
  input  wire logic       ndac_b_i,
  input  wire logic       eoi_b_i,
  input  wire logic [7:0] dio_b_i,
  gpl_sync_if.src         bus
);
  // ==========================================================
  // Two stage synchroniser, converts to active high
  logic [14:0] meta;
  logic [14:0] sync;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= 15'h7FFF;
      sync <= 15'h7FFF;
    end else begin
      meta <= {atn_b_i, ifc_b_i, ren_b_i, dav_b_i, nrfd_b_i, ndac_b_i,
               eoi_b_i, dio_b_i};
      sync <= meta;
    end
  end

  assign bus.atn  = ~sync[14];
  assign bus.ifc  = ~sync[13];
  assign bus.ren  = ~sync[12];
  assign bus.dav  = ~sync[11];
  assign bus.nrfd = ~sync[10];
  assign bus.ndac = ~sync[9];
  assign bus.eoi  = ~sync[8];
  assign bus.dio  = ~sync[7:0];
endmodule : gpl_sync

//--- tb/gpl_port_props.sv
`timescale 1ns/100ps
module gpl_port_props (
  input wire logic       sys_clk_i,
  input wire logic       rst_b_i,
  input wire logic       atn_b_i,
  input wire logic       ifc_b_i,
  input wire logic       ren_b_i,
  input wire logic       ndac_b_i,
  input wire logic       cmd_set_i,
  input wire logic       remote_req_i,
  input wire logic       remote_val_i,
  input wire logic       lockout_val_i,
  input wire logic       rx_ready_i,
  input wire logic [7:0] dio_oe_o,
  input wire logic       dav_oe_o,
  input wire logic       remote_o,
  input wire logic       lockout_o,
  input wire logic       ctrl_present_o,
  input wire logic       legacy_sel_o,
  input wire logic       rx_valid_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // Port checks
  sequence s_ren_still;
    $stable(ren_b_i) [*5];
  endsequence
  sequence s_atn_held;
    (!atn_b_i) [*5];
  endsequence
  chk_ren_present: assert property (
    s_ren_still |-> ctrl_present_o == !ren_b_i) else $error("ren flag");
  chk_remote_cause: assert property (
    $changed(remote_o) |-> $past(remote_req_i)) else $error("remote");
  chk_lock_cause: assert property (
    $changed(lockout_o) |-> $past(remote_req_i)) else $error("lockout");
  chk_remote_load: assert property (remote_req_i |=>
    remote_o == $past(remote_val_i) && lockout_o == $past(lockout_val_i))
    else $error("remote load");
  chk_no_ppoll: assert property (
    s_atn_held |-> dio_oe_o == 8'h00) else $error("data driven");
  chk_cmdset_copy: assert property ($changed(cmd_set_i) |=>
    legacy_sel_o == $past(cmd_set_i)) else $error("cmd set");
  chk_dav_hold: assert property (
    dav_oe_o && !ndac_b_i |=> dav_oe_o) else $error("dav dropped");
  chk_ifc_idle: assert property ((!ifc_b_i) [*5] |->
    dio_oe_o == 8'h00 && !dav_oe_o) else $error("ifc drive");
  chk_rx_kept: assert property (
    $fell(rx_valid_o) |-> $past(rx_ready_i)) else $error("rx lost");
endmodule // gpl_port_props

bind gpl_port gpl_port_props chk_u (.sys_clk_i(sys_clk_i),
  .rst_b_i(rst_b_i), .atn_b_i(atn_b_i), .ifc_b_i(ifc_b_i),
  .ren_b_i(ren_b_i), .ndac_b_i(ndac_b_i), .cmd_set_i(cmd_set_i),
  .remote_req_i(remote_req_i), .remote_val_i(remote_val_i),
  .lockout_val_i(lockout_val_i), .rx_ready_i(rx_ready_i),
  .dio_oe_o(dio_oe_o), .dav_oe_o(dav_oe_o), .remote_o(remote_o),
  .lockout_o(lockout_o), .ctrl_present_o(ctrl_present_o),
  .legacy_sel_o(legacy_sel_o), .rx_valid_o(rx_valid_o));

//--- tb/gpl_ctl_model.sv
`timescale 1ns/100ps
module gpl_ctl_model
  import gpl_pkg::*;
#(
  parameter logic [4:0] ADDR = 5'h0A
)
(
  input  wire logic       clk_i,
  input  wire logic       dav_b_i,
  input  wire logic       nrfd_b_i,
  input  wire logic       ndac_b_i,
  input  wire logic [7:0] dio_b_i,
  output logic            atn_o,
  output logic            eoi_o,
  output logic            ifc_o,
  output logic            dav_o,
  output logic            nrfd_o,
  output logic            ndac_o,
  output logic      [7:0] dio_o,
  output logic            failed_o
);
  localparam int TO = 300;
  initial begin
    {atn_o, eoi_o, ifc_o, dav_o, nrfd_o, ndac_o, failed_o} = 7'h00;
    dio_o = 8'h00;
  end
  // ==========================================================
  // Bus transfers
  task automatic src(input logic a, input logic [7:0] d, output bit ok);
    int n;
    n = 0;
    atn_o = a;
    dio_o = d;
    repeat (6) @(negedge clk_i);
    for (; !nrfd_b_i && n < TO; n++) @(negedge clk_i);
    dav_o = 1'b1;
    repeat (2) @(negedge clk_i);
    for (; !ndac_b_i && n < TO; n++) @(negedge clk_i);
    ok = (n < TO);
    dav_o = 1'b0;
    dio_o = 8'h00;
    @(negedge clk_i);
  endtask
  task automatic recv(output logic [7:0] d, output bit ok);
    int n;
    n = 0;
    atn_o = 1'b0;
    ndac_o = 1'b1;
    for (; dav_b_i && n < TO; n++) @(negedge clk_i);
    d = ~dio_b_i;
    nrfd_o = 1'b1;
    ndac_o = 1'b0;
    for (; !dav_b_i && n < TO; n++) @(negedge clk_i);
    ok = (n < TO);
    @(negedge clk_i);
    nrfd_o = 1'b0;
  endtask
  task automatic poll(output logic [7:0] s, output bit ok);
    bit k1, k2, k3, k4;
    src(1'b1, GPL_MSG_SPE, k1);
    src(1'b1, {GPL_GRP_TAG, ADDR}, k2);
    recv(s, k3);
    src(1'b1, GPL_MSG_SPD, k4);
    ok = k1 & k2 & k3 & k4;
  endtask
  task automatic ifc_pulse();
    ifc_o = 1'b1;
    repeat (8) @(negedge clk_i);
    ifc_o = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic ppoll(output logic [7:0] seen);
    seen = 8'h00;
    atn_o = 1'b1;
    eoi_o = 1'b1;
    repeat (8) begin
      @(negedge clk_i);
      seen = seen | ~dio_b_i;
    end
    eoi_o = 1'b0;
  endtask
  task automatic recover(output bit ok);
    logic [7:0] s;
    poll(s, ok);
    if (!ok) begin
      ifc_pulse();
      poll(s, ok);
    end
    failed_o = !ok;
  endtask
endmodule // gpl_ctl_model

//--- tb/gpl_port_bench.sv
`timescale 1ns/100ps
module gpl_port_bench
  import gpl_pkg::*;
;
  localparam logic [4:0] ADDR = 5'h0A;
  logic        sys_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        ren_t = 1'b0;
  logic        cmd_set_i = 1'b0;
  logic        remote_req_i = 1'b0;
  logic        remote_val_i = 1'b0;
  logic        lockout_val_i = 1'b0;
  logic        rx_ready_i = 1'b0;
  logic        tx_valid_i = 1'b0;
  logic        tx_last_i = 1'b0;
  logic  [7:0] tx_data_i = 8'h00;
  logic  [7:0] dio_oe_o, rx_data_o, dio_t, d, s, seen;
  logic        dav_oe_o, nrfd_oe_o, ndac_oe_o, remote_o, lockout_o;
  logic        ctrl_present_o, legacy_sel_o, rx_valid_o;
  logic        tx_ready_o, srq_oe_o, dev_clear_o;
  logic  [7:0] n_clear = 8'h00;
  logic        atn_t, eoi_t, ifc_t, dav_t, nrfd_t, ndac_t, failed;
  bit          ok;
  int          mismatches = 0;
  int          n_compared = 0;
  int unsigned seed;
  wire logic       dav_b = ~(dav_t | dav_oe_o);
  wire logic       nrfd_b = ~(nrfd_t | nrfd_oe_o);
  wire logic       ndac_b = ~(ndac_t | ndac_oe_o);
  wire logic [7:0] dio_b = ~(dio_t | dio_oe_o);
  logic [7:0] cmds [5] = '{{GPL_GRP_LAG, ADDR}, GPL_MSG_LLO, GPL_MSG_GTL,
                           GPL_MSG_PPC, GPL_MSG_PPU};
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(negedge sys_clk_i) begin
    if (dev_clear_o) n_clear <= n_clear + 8'h01;
  end
  gpl_port #(.BUS_ADDR(ADDR)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .atn_b_i(~atn_t),
    .ifc_b_i(~ifc_t), .ren_b_i(~ren_t), .dav_b_i(dav_b),
    .nrfd_b_i(nrfd_b), .ndac_b_i(ndac_b), .eoi_b_i(~eoi_t),
    .dio_b_i(dio_b), .dio_b_o(), .dio_oe_o(dio_oe_o), .dav_b_o(),
    .dav_oe_o(dav_oe_o), .nrfd_b_o(), .nrfd_oe_o(nrfd_oe_o),
    .ndac_b_o(), .ndac_oe_o(ndac_oe_o), .srq_b_o(),
    .srq_oe_o(srq_oe_o),
    .cmd_set_i(cmd_set_i), .remote_req_i(remote_req_i),
    .remote_val_i(remote_val_i), .lockout_val_i(lockout_val_i),
    .remote_o(remote_o), .lockout_o(lockout_o),
    .ctrl_present_o(ctrl_present_o), .legacy_sel_o(legacy_sel_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .tx_data_i(tx_data_i),
    .tx_valid_i(tx_valid_i), .tx_last_i(tx_last_i),
    .tx_ready_o(tx_ready_o), .dev_clear_o(dev_clear_o));
  gpl_ctl_model #(.ADDR(ADDR)) ctl_u (
    .clk_i(sys_clk_i), .dav_b_i(dav_b), .nrfd_b_i(nrfd_b),
    .ndac_b_i(ndac_b), .dio_b_i(dio_b), .atn_o(atn_t), .eoi_o(eoi_t),
    .ifc_o(ifc_t), .dav_o(dav_t), .nrfd_o(nrfd_t), .ndac_o(ndac_t),
    .dio_o(dio_t), .failed_o(failed));
  // ==========================================================
  // Checking helpers
  function automatic logic [7:0] f_stb(logic v, logic l);
    f_stb = 8'h00;
    f_stb[GPL_STB_BAV_BIT] = v;
    f_stb[GPL_STB_MAV_BIT] = v & l;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic need(input bit k);
    chk({7'h00, k}, 8'h01);
    if (!k) print_verdict();
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    seed = $urandom(32'h5FEA);
    repeat (2) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    ren_t = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    chk({7'h00, ctrl_present_o}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      {remote_val_i, lockout_val_i, cmd_set_i} = 3'($urandom);
      remote_req_i = 1'b1;
      @(negedge sys_clk_i);
      remote_req_i = 1'b0;
      @(negedge sys_clk_i);
      chk({remote_o, lockout_o}, {remote_val_i, lockout_val_i});
      chk({7'h00, legacy_sel_o}, {7'h00, cmd_set_i});
    end
    foreach (cmds[i]) begin
      ctl_u.src(1'b1, cmds[i], ok);
      need(ok);
    end
    ctl_u.ppoll(seen);
    chk(seen, 8'h00);
    ren_t = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    chk({remote_o, lockout_o}, {remote_val_i, lockout_val_i});
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      ctl_u.src(1'b0, d, ok);
      need(ok);
      if (i == 3) ctl_u.ifc_pulse();
      chk(rx_data_o, d);
      chk({7'h00, rx_valid_o}, 8'h01);
      rx_ready_i = 1'b1;
      @(negedge sys_clk_i);
      rx_ready_i = 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      {tx_valid_i, tx_last_i} = 2'(i);
      tx_data_i = 8'($urandom);
      ctl_u.poll(s, ok);
      need(ok);
      chk(s & 8'h12, f_stb(tx_valid_i, tx_last_i));
    end
    ctl_u.src(1'b1, {GPL_GRP_TAG, ADDR}, ok);
    fork
      ctl_u.recv(d, ok);
      begin
        for (int n = 0; !tx_ready_o && n < 100; n++) @(negedge sys_clk_i);
        chk({7'h00, tx_ready_o}, 8'h01);
        @(negedge sys_clk_i);
        tx_valid_i = 1'b0;
      end
    join
    need(ok);
    chk(d, tx_data_i);
    ctl_u.src(1'b1, GPL_MSG_UNT, ok);
    need(ok);
    {tx_valid_i, tx_last_i} = 2'h3;
    repeat (3) @(negedge sys_clk_i);
    chk({7'h00, srq_oe_o}, 8'h01);
    ctl_u.poll(s, ok);
    need(ok);
    chk(s & 8'h52, f_stb(1'b1, 1'b1) | 8'h40);
    chk({7'h00, srq_oe_o}, 8'h00);
    ctl_u.src(1'b1, GPL_MSG_DCL, ok);
    need(ok);
    repeat (2) @(negedge sys_clk_i);
    chk(n_clear, 8'h01);
    tx_valid_i = 1'b0;
    ctl_u.src(1'b1, {GPL_GRP_TAG, ADDR}, ok);
    ctl_u.recv(d, ok);
    chk({7'h00, ok}, 8'h00);
    ctl_u.recover(ok);
    need(ok);
    chk({7'h00, failed}, 8'h00);
    print_verdict();
  end
endmodule // gpl_port_bench
